// >>> core/crf_pkg.sv
package crf_pkg;

    // Register offsets on the APB side (byte addresses, one word each)
    localparam logic [11:0] OFF_ACC = 12'h000;
    localparam logic [11:0] OFF_IDX_X = 12'h004;
    localparam logic [11:0] OFF_IDX_Y = 12'h008;
    localparam logic [11:0] OFF_STACK = 12'h00c;
    localparam logic [11:0] OFF_FLAGS = 12'h010;
    localparam logic [11:0] OFF_PAIR = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;

    // Flag positions in the processor_flag_word
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_I = 2;
    localparam int FLAG_H = 3;
    localparam int FLAG_B = 4;
    localparam int FLAG_G = 5;
    localparam int FLAG_V = 6;
    localparam int FLAG_N = 7;

    // Status register fields
    localparam int STAT_FAULT = 0;
    localparam int STAT_GRANT = 1;

    // Reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_IDX = 8'h00;
    localparam logic [7:0] RST_STACK = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;

    // Stack window and frame sizes
    localparam logic [7:0] STACK_TOP = 8'hbf;
    localparam logic [7:0] CALL_FRAME = 8'h02;
    localparam logic [7:0] IRQ_FRAME = 8'h03;

    typedef enum logic [5:0] {
        OP_NOP, OP_LDA, OP_LDX, OP_LDY, OP_LDYA,
        OP_ADC, OP_SBC, OP_CMPA, OP_AND, OP_OR, OP_EOR,
        OP_ASL, OP_LSR, OP_ROL, OP_ROR,
        OP_INCX, OP_DECX, OP_INCY, OP_DECY, OP_CMPX, OP_CMPY,
        OP_BITT, OP_EI, OP_DI, OP_SELECT_UPPER_PAGE_INSTR, OP_SELECT_ZERO_PAGE_INSTR, OP_CLEAR_OVERFLOW_INSTR,
        OP_SETC, OP_CLRC, OP_BRK, OP_CALL, OP_RET, OP_IRQ, OP_RETI,
        OP_IDXA, OP_DIRA, OP_LDSP
    } crf_op_t;

    typedef enum logic {IDX_X, IDX_Y} crf_idx_t;

    typedef struct packed {
        crf_op_t op;
        crf_idx_t idx;
        logic [7:0] operand;
        logic [7:0] operand_hi;
        logic [15:0] base;
    } crf_cmd_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] sp;
        logic [7:0] processor_flag_word;
        logic [15:0] pair;
        logic [15:0] eff_addr;
    } crf_state_t;

endpackage : crf_pkg

// >>> core/crf_core_regs.sv
// Behaviour
// - Eight-bit accumulator for arithmetic and transfers
// - Accumulator plus Y form one 16-bit pair
// - Indexed address is base plus X or Y
// - X and Y increment, decrement, compare, load
// - Eight-bit stack pointer names next save slot
// - Stack lives between 00H and 0BFH
// - Calls and interrupts move the stack pointer
// - Carry takes ALU carry, shifts and rotates
// - Zero set on zero result, else cleared
// - Interrupt flag low blocks all but break
// - Interrupt flag cleared on service, set/clear instrs
// - Half carry from bit 3, cleared by clear-overflow
// - Break flag set by software break
// - Direct page flag picks page 0 or 1
// - Upper page instr sets, zero page clears
// - Overflow on signed result beyond 7FH/80H
// - Clear-overflow clears V, as can arithmetic; no set-V instr
// - Bit test copies operand bit 6 to V
// - Negative follows result bit 7
// - Bit test copies operand bit 7 to N
module crf_core_regs (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire crf_pkg::crf_cmd_t DEC_CMD,
    input wire logic IRQ_REQ,
    output crf_pkg::crf_state_t CORE_STATE,
    output logic IRQ_GRANT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import crf_pkg::*;

    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic [7:0] x_r;
    logic [7:0] x_nxt;
    logic [7:0] y_r;
    logic [7:0] y_nxt;
    logic [7:0] sp_r;
    logic [7:0] sp_nxt;
    logic [7:0] psw_r;
    logic [7:0] psw_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic fault_r;
    logic fault_nxt;
    logic fault_set;
    logic grant_r;
    logic pready_r;
    logic perr_r;
    logic [31:0] prdata_r;

    // Set N and Z from a result byte
    function automatic logic [7:0] with_nz(input logic [7:0] p, input logic [7:0] r);
        logic [7:0] q;
        q = p;
        q[FLAG_N] = r[7];
        q[FLAG_Z] = (r == 8'h00);
        return q;
    endfunction : with_nz

    // Adder operand selection; compares reuse the subtract path
    wire crf_op_t op = DEC_CMD.op;
    wire is_sub = (op == OP_SBC) || (op == OP_CMPA) || (op == OP_CMPX) || (op == OP_CMPY);
    wire is_cmp = (op == OP_CMPA) || (op == OP_CMPX) || (op == OP_CMPY);
    wire [7:0] alu_a = (op == OP_CMPX) ? x_r : ((op == OP_CMPY) ? y_r : acc_r);
    wire [7:0] alu_b = is_sub ? ~DEC_CMD.operand : DEC_CMD.operand;
    wire alu_cin = is_cmp ? 1'b1 : psw_r[FLAG_C];
    wire [8:0] alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
    wire [4:0] alu_low = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
    wire alu_ovf = (alu_a[7] == alu_b[7]) && (alu_sum[7] != alu_a[7]);

    // Stack arithmetic in nine bits so wrap below zero shows as large
    wire [8:0] sp_dn_call = {1'b0, sp_r} - {1'b0, CALL_FRAME};
    wire [8:0] sp_dn_irq = {1'b0, sp_r} - {1'b0, IRQ_FRAME};
    wire [8:0] sp_up_call = {1'b0, sp_r} + {1'b0, CALL_FRAME};
    wire [8:0] sp_up_irq = {1'b0, sp_r} + {1'b0, IRQ_FRAME};
    wire [8:0] stack_lim = {1'b0, STACK_TOP};

    // Indexed and direct effective addresses
    wire [7:0] idx_val = (DEC_CMD.idx == IDX_Y) ? y_r : x_r;
    wire [15:0] idx_addr = DEC_CMD.base + {8'h00, idx_val};
    wire [15:0] dir_addr = {7'h00, psw_r[FLAG_G], DEC_CMD.operand};

    // APB decode; one wait state, write commits on the ready edge
    wire apb_setup = PSEL && PENABLE && !pready_r;
    wire apb_wr = PSEL && PENABLE && PWRITE && pready_r;
    wire hit_acc = (PADDR == OFF_ACC);
    wire hit_x = (PADDR == OFF_IDX_X);
    wire hit_y = (PADDR == OFF_IDX_Y);
    wire hit_sp = (PADDR == OFF_STACK);
    wire hit_psw = (PADDR == OFF_FLAGS);
    wire hit_pair = (PADDR == OFF_PAIR);
    wire hit_stat = (PADDR == OFF_STATUS);
    wire hit_any = hit_acc || hit_x || hit_y || hit_sp || hit_psw || hit_pair || hit_stat;
    // Stack pointer writes outside the window are refused, not clamped
    wire sp_bad = PWRITE && hit_sp && (PWDATA[7:0] > STACK_TOP);
    wire apb_err = !hit_any || sp_bad;
    wire sp_wr_ok = apb_wr && hit_sp && (PWDATA[7:0] <= STACK_TOP);
    wire [31:0] rd_mux =
        hit_acc ? {24'h000000, acc_r} :
        hit_x ? {24'h000000, x_r} :
        hit_y ? {24'h000000, y_r} :
        hit_sp ? {24'h000000, sp_r} :
        hit_psw ? {24'h000000, psw_r} :
        hit_pair ? {16'h0000, y_r, acc_r} :
        hit_stat ? {30'h0, grant_r, fault_r} : 32'h00000000;

    // Next state of the register set from the decoder command
    always_comb
    begin
        acc_nxt = acc_r;
        x_nxt = x_r;
        y_nxt = y_r;
        sp_nxt = sp_r;
        psw_nxt = psw_r;
        addr_nxt = addr_r;
        fault_set = 1'b0;
        unique case (op)
            OP_NOP:
            begin
                acc_nxt = acc_r;
            end
            OP_LDA:
            begin
                acc_nxt = DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, DEC_CMD.operand);
            end
            OP_LDX:
            begin
                x_nxt = DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, DEC_CMD.operand);
            end
            OP_LDY:
            begin
                y_nxt = DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, DEC_CMD.operand);
            end
            OP_LDYA:
            begin
                // Pair load: Y takes the high byte, flags see all 16 bits
                acc_nxt = DEC_CMD.operand;
                y_nxt = DEC_CMD.operand_hi;
                psw_nxt[FLAG_N] = DEC_CMD.operand_hi[7];
                psw_nxt[FLAG_Z] = ({DEC_CMD.operand_hi, DEC_CMD.operand} == 16'h0000);
            end
            OP_ADC, OP_SBC:
            begin
                acc_nxt = alu_sum[7:0];
                psw_nxt = with_nz(psw_r, alu_sum[7:0]);
                psw_nxt[FLAG_C] = alu_sum[8];
                psw_nxt[FLAG_H] = alu_low[4];
                psw_nxt[FLAG_V] = alu_ovf;
            end
            OP_CMPA, OP_CMPX, OP_CMPY:
            begin
                // Compare leaves the operands alone; carry means no borrow
                psw_nxt = with_nz(psw_r, alu_sum[7:0]);
                psw_nxt[FLAG_C] = alu_sum[8];
            end
            OP_AND:
            begin
                acc_nxt = acc_r & DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, acc_r & DEC_CMD.operand);
            end
            OP_OR:
            begin
                acc_nxt = acc_r | DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, acc_r | DEC_CMD.operand);
            end
            OP_EOR:
            begin
                acc_nxt = acc_r ^ DEC_CMD.operand;
                psw_nxt = with_nz(psw_r, acc_r ^ DEC_CMD.operand);
            end
            OP_ASL, OP_ROL:
            begin
                acc_nxt = {acc_r[6:0], (op == OP_ROL) && psw_r[FLAG_C]};
                psw_nxt = with_nz(psw_r, {acc_r[6:0], (op == OP_ROL) && psw_r[FLAG_C]});
                psw_nxt[FLAG_C] = acc_r[7];
            end
            OP_LSR, OP_ROR:
            begin
                acc_nxt = {(op == OP_ROR) && psw_r[FLAG_C], acc_r[7:1]};
                psw_nxt = with_nz(psw_r, {(op == OP_ROR) && psw_r[FLAG_C], acc_r[7:1]});
                psw_nxt[FLAG_C] = acc_r[0];
            end
            OP_INCX:
            begin
                x_nxt = x_r + 8'h01;
                psw_nxt = with_nz(psw_r, x_r + 8'h01);
            end
            OP_DECX:
            begin
                x_nxt = x_r - 8'h01;
                psw_nxt = with_nz(psw_r, x_r - 8'h01);
            end
            OP_INCY:
            begin
                y_nxt = y_r + 8'h01;
                psw_nxt = with_nz(psw_r, y_r + 8'h01);
            end
            OP_DECY:
            begin
                y_nxt = y_r - 8'h01;
                psw_nxt = with_nz(psw_r, y_r - 8'h01);
            end
            OP_BITT:
            begin
                // Z from the masked value, N and V straight from memory
                psw_nxt[FLAG_Z] = ((acc_r & DEC_CMD.operand) == 8'h00);
                psw_nxt[FLAG_V] = DEC_CMD.operand[6];
                psw_nxt[FLAG_N] = DEC_CMD.operand[7];
            end
            OP_EI:
            begin
                psw_nxt[FLAG_I] = 1'b1;
            end
            OP_DI:
            begin
                psw_nxt[FLAG_I] = 1'b0;
            end
            OP_SELECT_UPPER_PAGE_INSTR:
            begin
                psw_nxt[FLAG_G] = 1'b1;
            end
            OP_SELECT_ZERO_PAGE_INSTR:
            begin
                psw_nxt[FLAG_G] = 1'b0;
            end
            OP_CLEAR_OVERFLOW_INSTR:
            begin
                psw_nxt[FLAG_V] = 1'b0;
                psw_nxt[FLAG_H] = 1'b0;
            end
            OP_SETC:
            begin
                psw_nxt[FLAG_C] = 1'b1;
            end
            OP_CLRC:
            begin
                psw_nxt[FLAG_C] = 1'b0;
            end
            OP_BRK:
            begin
                // Break is never masked; it frames like an interrupt
                sp_nxt = sp_dn_irq[7:0];
                fault_set = (sp_dn_irq > stack_lim);
                psw_nxt[FLAG_B] = 1'b1;
                psw_nxt[FLAG_I] = 1'b0;
            end
            OP_CALL:
            begin
                sp_nxt = sp_dn_call[7:0];
                fault_set = (sp_dn_call > stack_lim);
            end
            OP_RET:
            begin
                sp_nxt = sp_up_call[7:0];
                fault_set = (sp_up_call > stack_lim);
            end
            OP_IRQ:
            begin
                // Return address plus flag word go on the stack
                sp_nxt = sp_dn_irq[7:0];
                fault_set = (sp_dn_irq > stack_lim);
                psw_nxt[FLAG_I] = 1'b0;
            end
            OP_RETI:
            begin
                sp_nxt = sp_up_irq[7:0];
                fault_set = (sp_up_irq > stack_lim);
                psw_nxt = DEC_CMD.operand;
            end
            OP_IDXA:
            begin
                addr_nxt = idx_addr;
            end
            OP_DIRA:
            begin
                addr_nxt = dir_addr;
            end
            OP_LDSP:
            begin
                // Start value comes from software; reset only loads RST_STACK (00H)
                sp_nxt = DEC_CMD.operand;
                fault_set = (DEC_CMD.operand > STACK_TOP);
            end
            default:
            begin
                acc_nxt = acc_r;
            end
        endcase
        // A bus write lands after the decoder and so overrides it
        if (apb_wr && hit_acc)
        begin
            acc_nxt = PWDATA[7:0];
        end
        if (apb_wr && hit_x)
        begin
            x_nxt = PWDATA[7:0];
        end
        if (apb_wr && hit_y)
        begin
            y_nxt = PWDATA[7:0];
        end
        if (apb_wr && hit_pair)
        begin
            acc_nxt = PWDATA[7:0];
            y_nxt = PWDATA[15:8];
        end
        if (sp_wr_ok)
        begin
            sp_nxt = PWDATA[7:0];
        end
        if (apb_wr && hit_psw)
        begin
            psw_nxt = PWDATA[7:0];
        end
    end

    // Sticky stack fault: write one to clear, a new fault wins
    assign fault_nxt = fault_set || (fault_r && !(apb_wr && hit_stat && PWDATA[STAT_FAULT]));

    // Architectural registers
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            acc_r <= RST_ACC;
            x_r <= RST_IDX;
            y_r <= RST_IDX;
            sp_r <= RST_STACK;
            psw_r <= RST_FLAGS;
            addr_r <= RST_ADDR;
        end
        else
        begin
            acc_r <= acc_nxt;
            x_r <= x_nxt;
            y_r <= y_nxt;
            sp_r <= sp_nxt;
            psw_r <= psw_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Interrupt gate and fault flag
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            grant_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            grant_r <= IRQ_REQ && psw_r[FLAG_I];
            fault_r <= fault_nxt;
        end
    end

    // APB answer: ready, error and read data all registered
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pready_r <= 1'b0;
            perr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            pready_r <= apb_setup;
            perr_r <= apb_setup && apb_err;
            prdata_r <= (apb_setup && !PWRITE) ? rd_mux : 32'h00000000;
        end
    end

    // Outputs are flops or plain concatenations of flops
    assign CORE_STATE.acc = acc_r;
    assign CORE_STATE.x = x_r;
    assign CORE_STATE.y = y_r;
    assign CORE_STATE.sp = sp_r;
    assign CORE_STATE.processor_flag_word = psw_r;
    assign CORE_STATE.pair = {y_r, acc_r};
    assign CORE_STATE.eff_addr = addr_r;
    assign IRQ_GRANT = grant_r;
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = perr_r;

endmodule : crf_core_regs

// >>> tb/crf_core_regs_sva.sv
module crf_core_regs_sva
    import crf_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire crf_pkg::crf_cmd_t DEC_CMD,
    input wire logic IRQ_REQ,
    input wire crf_pkg::crf_state_t CORE_STATE,
    input wire logic IRQ_GRANT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic PREADY
);
    timeunit 1ns;
    timeprecision 1ps;

    // Decoder op seen only when no bus write can override it
    wire logic quiet = !(PSEL && PENABLE && PWRITE);
    wire crf_op_t op = crf_op_t'(quiet ? DEC_CMD.op : OP_NOP);
    wire logic [7:0] processor_flag_word = CORE_STATE.processor_flag_word;
    wire logic ei = op == OP_EI;
    wire logic g_set = op == OP_SELECT_UPPER_PAGE_INSTR;
    wire logic [15:0] hi_lo = {DEC_CMD.operand_hi, DEC_CMD.operand};
    wire logic [7:0] ix = (DEC_CMD.idx == IDX_Y) ? CORE_STATE.y : CORE_STATE.x;
    wire logic [15:0] idx_sum = DEC_CMD.base + {8'h00, ix};
    // Gate input as one signal so the grant check delays a plain net
    wire logic gate_in = IRQ_REQ && processor_flag_word[FLAG_I];

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // Grant, flag, register, address and bus-ready effects one cycle after their cause
    grant_gate_a: assert property (IRQ_GRANT == $past(gate_in))
        else $error("grant not gated by enable flag");
    irq_mask_a: assert property (op inside {OP_EI, OP_DI, OP_IRQ, OP_BRK}
        |=> processor_flag_word[FLAG_I] == $past(ei)) else $error("interrupt flag wrong");
    page_sel_a: assert property (op inside {OP_SELECT_UPPER_PAGE_INSTR, OP_SELECT_ZERO_PAGE_INSTR}
        |=> processor_flag_word[FLAG_G] == $past(g_set)) else $error("page flag wrong");
    call_depth_a: assert property (op == OP_CALL
        |=> CORE_STATE.sp == $past(CORE_STATE.sp) - 8'h02) else $error("call depth wrong");
    clr_ovf_a: assert property (op == OP_CLEAR_OVERFLOW_INSTR
        |=> !processor_flag_word[FLAG_V] && !processor_flag_word[FLAG_H]) else $error("overflow clear failed");
    bit_copy_a: assert property (op == OP_BITT
        |=> processor_flag_word[7:6] == $past(DEC_CMD.operand[7:6])) else $error("bit test copy wrong");
    load_flags_a: assert property (op == OP_LDA |=> CORE_STATE.acc == $past(DEC_CMD.operand)
        && processor_flag_word[FLAG_Z] == (CORE_STATE.acc == 8'h00) && processor_flag_word[FLAG_N] == CORE_STATE.acc[7])
        else $error("load flags wrong");
    pair_load_a: assert property (op == OP_LDYA |=> CORE_STATE.pair == $past(hi_lo))
        else $error("pair load wrong");
    index_add_a: assert property (op == OP_IDXA |=> CORE_STATE.eff_addr == $past(idx_sum))
        else $error("indexed address wrong");
    ready_pulse_a: assert property ($rose(PENABLE) |=> PREADY ##1 !PREADY)
        else $error("bus answer timing wrong");
endmodule : crf_core_regs_sva

// >>> tb/crf_dec_model.sv
module crf_dec_model
    import crf_pkg::*;
(
    input wire logic CORE_CLK,
    output crf_pkg::crf_cmd_t DEC_CMD,
    output logic IRQ_REQ
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle decoder, nothing pending
    initial
    begin
        DEC_CMD = '0;
        IRQ_REQ = 1'b0;
    end

    // One command, then idle with scrambled fields so stale data is never reused
    task automatic exec(input crf_op_t op, input logic [7:0] v, input logic [7:0] hi,
        input logic [15:0] b, input crf_idx_t ix);
        DEC_CMD <= '{op: op, idx: ix, operand: v, operand_hi: hi, base: b};
        @(posedge CORE_CLK);
        DEC_CMD <= '{op: OP_NOP, idx: ix, operand: ~v, operand_hi: ~hi, base: ~b};
        @(posedge CORE_CLK);
    endtask : exec

    // Level request, changed just after an edge
    task automatic irq(input logic v);
        IRQ_REQ <= v;
    endtask : irq
endmodule : crf_dec_model

// >>> tb/test_crf_core_regs.sv
module test_crf_core_regs
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq_grant, irq_req, er;
    crf_cmd_t dec_cmd;
    crf_state_t st;
    int err_count = 0;
    int comparisons = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    crf_core_regs crf_core_regs_i (.CORE_CLK(clk), .RST_N(rst_n), .DEC_CMD(dec_cmd),
        .IRQ_REQ(irq_req), .CORE_STATE(st), .IRQ_GRANT(irq_grant), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    crf_dec_model crf_dec_model_i (.CORE_CLK(clk), .DEC_CMD(dec_cmd), .IRQ_REQ(irq_req));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk

    // Setup, access until ready, then release for one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask : apb

    task automatic ex(input crf_op_t op, input logic [7:0] v = 8'h00,
        input logic [7:0] hi = 8'h00, input logic [15:0] b = 16'h0000, input crf_idx_t ix = IDX_X);
        crf_dec_model_i.exec(op, v, hi, b, ix);
    endtask : ex

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // Hang guard, run needs well under a thousand cycles
    initial
    begin
        #40000;
        err_count++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a <= 16; a += 4)
        begin
            apb(1'b0, a[11:0], 32'h0);
            chk(rd[15:0], 16'h0000);
        end
        ex(OP_LDA, 8'h7f);
        ex(OP_CLRC);
        ex(OP_ADC, 8'h01);
        chk({st.acc, st.processor_flag_word}, 16'h80c8);
        ex(OP_CLEAR_OVERFLOW_INSTR);
        chk({st.acc, st.processor_flag_word}, 16'h8080);
        ex(OP_LDA, 8'h80);
        ex(OP_ADC, 8'h80);
        chk({st.acc, st.processor_flag_word}, 16'h0043);
        ex(OP_SBC, 8'h01);
        chk({st.acc, st.processor_flag_word}, 16'hff80);
        ex(OP_ASL);
        chk({st.acc, 7'h0, st.processor_flag_word[FLAG_C]}, 16'hfe01);
        ex(OP_ROL);
        chk({st.acc, 7'h0, st.processor_flag_word[FLAG_C]}, 16'hfd01);
        ex(OP_LSR);
        chk({st.acc, 7'h0, st.processor_flag_word[FLAG_C]}, 16'h7e01);
        ex(OP_ROR);
        chk({st.acc, 7'h0, st.processor_flag_word[FLAG_C]}, 16'hbf00);
        ex(OP_LDX, 8'hff);
        ex(OP_INCX);
        chk({st.x, 6'h0, st.processor_flag_word[7], st.processor_flag_word[1]}, 16'h0001);
        ex(OP_DECY);
        chk({st.y, 6'h0, st.processor_flag_word[7], st.processor_flag_word[1]}, 16'hff02);
        ex(OP_CMPX, 8'h00);
        chk({st.x, 6'h0, st.processor_flag_word[1:0]}, 16'h0003);
        ex(OP_INCY);
        ex(OP_DECX);
        ex(OP_CMPY, 8'h01);
        chk({st.x, st.y}, 16'hff00);
        chk({14'h0, st.processor_flag_word[1:0]}, 16'h0000);
        ex(OP_LDYA, 8'h34, 8'h12);
        chk(st.pair, 16'h1234);
        apb(1'b0, OFF_PAIR, 32'h0);
        chk(rd[15:0], 16'h1234);
        chk(rd[31:16], 16'h0000);
        apb(1'b1, OFF_PAIR, 32'h5678);
        chk({st.y, st.acc}, 16'h5678);
        ex(OP_IDXA, 8'h00, 8'h00, 16'h1000, IDX_Y);
        chk(st.eff_addr, 16'h1056);
        ex(OP_IDXA, 8'h00, 8'h00, 16'h10f0, IDX_X);
        chk(st.eff_addr, 16'h11ef);
        ex(OP_SELECT_UPPER_PAGE_INSTR);
        ex(OP_DIRA, 8'h42);
        chk(st.eff_addr, 16'h0142);
        ex(OP_SELECT_ZERO_PAGE_INSTR);
        ex(OP_DIRA, 8'h42);
        chk(st.eff_addr, 16'h0042);
        ex(OP_BITT, 8'h40);
        chk({13'h0, st.processor_flag_word[7:6], st.processor_flag_word[1]}, 16'h0002);
        ex(OP_BITT, 8'h80);
        chk({13'h0, st.processor_flag_word[7:6], st.processor_flag_word[1]}, 16'h0005);
        ex(OP_EI);
        crf_dec_model_i.irq(1'b1);
        repeat (2) @(posedge clk);
        chk({15'h0, irq_grant}, 16'h0001);
        ex(OP_DI);
        @(posedge clk);
        chk({15'h0, irq_grant}, 16'h0000);
        crf_dec_model_i.irq(1'b0);
        ex(OP_LDSP, 8'hbf);
        ex(OP_CALL);
        chk({8'h0, st.sp}, 16'h00bd);
        ex(OP_EI);
        ex(OP_IRQ);
        chk({st.sp, 7'h0, st.processor_flag_word[FLAG_I]}, 16'hba00);
        ex(OP_RETI, 8'ha5);
        chk({st.sp, st.processor_flag_word}, 16'hbda5);
        ex(OP_RET);
        ex(OP_BRK);
        chk({st.sp, st.processor_flag_word}, 16'hbcb1);
        apb(1'b1, OFF_STACK, 32'hc0);
        chk({st.sp, 7'h0, er}, 16'hbc01);
        ex(OP_LDSP, 8'h00);
        ex(OP_CALL);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk({st.sp, rd[7:0]}, 16'hfe01);
        apb(1'b1, OFF_STATUS, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[15:0], 16'h0000);
        apb(1'b0, 12'h01c, 32'h0);
        chk({rd[14:0], er}, 16'h0001);
        apb(1'b1, OFF_FLAGS, 32'h5a);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk(rd[15:0], 16'h005a);
        // Plain bus writes to accumulator, X, Y and stack, stack value inside the window
        apb(1'b1, OFF_ACC, 32'h11);
        apb(1'b1, OFF_IDX_X, 32'h22);
        apb(1'b1, OFF_IDX_Y, 32'h33);
        apb(1'b1, OFF_STACK, 32'hbf);
        chk({st.acc, st.x}, 16'h1122);
        chk({st.y, st.sp}, 16'h33bf);
        chk({15'h0, er}, 16'h0000);
        // Logic ops and accumulator compare, carry preset so the compare must clear it
        ex(OP_SETC);
        chk({15'h0, st.processor_flag_word[FLAG_C]}, 16'h0001);
        ex(OP_LDA, 8'hf0);
        ex(OP_AND, 8'h3c);
        chk({st.acc, 6'h0, st.processor_flag_word[FLAG_N], st.processor_flag_word[FLAG_Z]}, 16'h3000);
        ex(OP_OR, 8'h8f);
        chk({st.acc, 6'h0, st.processor_flag_word[FLAG_N], st.processor_flag_word[FLAG_Z]}, 16'hbf02);
        ex(OP_EOR, 8'hbf);
        chk({st.acc, 6'h0, st.processor_flag_word[FLAG_N], st.processor_flag_word[FLAG_Z]}, 16'h0001);
        ex(OP_CMPA, 8'h01);
        chk({st.acc, 6'h0, st.processor_flag_word[FLAG_N], st.processor_flag_word[FLAG_C]}, 16'h0002);
        // Grant readable in the status word
        ex(OP_EI);
        crf_dec_model_i.irq(1'b1);
        repeat (2) @(posedge clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[15:0], 16'h0002);
        crf_dec_model_i.irq(1'b0);
        test_done();
    end
endmodule : test_crf_core_regs

bind crf_core_regs crf_core_regs_sva crf_core_regs_sva_i (.CORE_CLK, .RST_N, .DEC_CMD,
    .IRQ_REQ, .CORE_STATE, .IRQ_GRANT, .PSEL, .PENABLE, .PWRITE, .PREADY);
